// *** shared/shiu_pkg.sv ***
// Shared constants and carrier types for the system hint instruction unit.
// Assumes a single core clock domain and a 32-bit APB register bus.
package shiu_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] SHIU_CTRL_OFF   = 8'h00;
  localparam logic [7:0] SHIU_STATE_OFF  = 8'h04;
  localparam logic [7:0] SHIU_IRQ_ST_OFF = 8'h08;
  localparam logic [7:0] SHIU_IRQ_MK_OFF = 8'h0C;

  // Control fields
  localparam int SHIU_CTRL_EVPEND_POS = 0;
  localparam int SHIU_CTRL_DBGEN_POS  = 1;

  // Status and mask bit positions
  localparam int SHIU_IRQ_SVC_POS   = 0;
  localparam int SHIU_IRQ_SEV_POS   = 1;
  localparam int SHIU_IRQ_WAKE_POS  = 2;
  localparam int SHIU_IRQ_FLUSH_POS = 3;
  localparam int SHIU_IRQ_W         = 4;

  // Reset values
  localparam logic [31:0] SHIU_WORD_RST   = 32'h0000_0000;
  localparam logic [7:0]  SHIU_BPRI_RST   = 8'h00;
  localparam logic        SHIU_EVREG_RST  = 1'b0;
  localparam logic [1:0]  SHIU_CTRL_RST   = 2'h0;
  localparam logic [3:0]  SHIU_IRQ_RST    = 4'h0;

  // Program status word layout
  localparam int SHIU_FLAG_HI    = 31;
  localparam int SHIU_FLAG_LO    = 27;
  localparam int SHIU_EXEC_HI    = 26;
  localparam int SHIU_EXEC_LO    = 9;
  localparam logic [31:0] SHIU_APP_MASK = 32'hF800_0000;

  // Special register selectors
  typedef enum logic [3:0] {
    SHIU_SR_APP   = 4'h0,
    SHIU_SR_PSW   = 4'h1,
    SHIU_SR_MSP   = 4'h2,
    SHIU_SR_PSP   = 4'h3,
    SHIU_SR_IMASK = 4'h4,
    SHIU_SR_BPRI  = 4'h5,
    SHIU_SR_BPMAX = 4'h6,
    SHIU_SR_FMASK = 4'h7,
    SHIU_SR_CTRL  = 4'h8
  } shiu_sreg_e;

  // Instruction operations
  typedef enum logic [3:0] {
    SHIU_OP_NOP  = 4'h0,
    SHIU_OP_ISB  = 4'h1,
    SHIU_OP_MRS  = 4'h2,
    SHIU_OP_MSR  = 4'h3,
    SHIU_OP_SEV  = 4'h4,
    SHIU_OP_SVC  = 4'h5,
    SHIU_OP_WFE  = 4'h6,
    SHIU_OP_WFI  = 4'h7
  } shiu_op_e;

  // Sleep machine states
  typedef enum logic [1:0] {
    SHIU_RUN       = 2'b00,
    SHIU_SLEEP_EVT = 2'b01,
    SHIU_SLEEP_INT = 2'b10
  } shiu_state_e;

  // Instruction issued by fetch
  typedef struct packed {
    logic        valid;
    shiu_op_e    op;
    shiu_sreg_e  sreg;
    logic [31:0] src;
    logic [7:0]  imm;
  } shiu_instr_s;

  // Result returned to the pipeline
  typedef struct packed {
    logic        rd_valid;
    logic [31:0] rd_data;
    logic        svc_raise;
    logic [7:0]  svc_imm;
    logic        flush;
  } shiu_result_s;

  // Wake sources from exception and debug logic
  typedef struct packed {
    logic exc_unmasked;
    logic exc_any;
    logic exc_new_pend;
    logic dbg_req;
    logic ext_event;
  } shiu_wake_s;

endpackage

// *** rtl/shiu_core.sv ***
// System hint instruction unit: barrier, special register moves,
// event and sleep hints, supervisor call, with an APB register port.
// Assumes one core clock; wake inputs come from logic on that clock.
//
// Functional notes
// - barrier flushes pipeline for refetch
// - special read copies selected register out
// - raise alias reads as base priority
// - unprivileged write reaches application flags only
// - unprivileged ignores unallocated and execution bits
// - raise alias writes only when raising
// - special write sets flags from source
// - no operation has no effect
// - send event signals out, sets event
// - supervisor call raises exception, keeps immediate
// - wait for event sleeps when clear
// - event sleep wakes on listed sources
// - wait with event set clears, continues
// - wait for interrupt wakes on exception, debug
// - other instructions keep flags unchanged
`timescale 1ns/1ps
`default_nettype none

module shiu_core (
  input  wire logic                  clock,
  input  wire logic                  rst_b,
  input  wire shiu_pkg::shiu_instr_s instr,
  input  wire logic                  privileged,
  input  wire shiu_pkg::shiu_wake_s  wake,
  output var  shiu_pkg::shiu_result_s result,
  output logic                       instr_ready,
  output logic                       core_sleeping,
  output logic                       event_out,
  output logic [31:0]                psw_out,
  output logic [7:0]                 base_pri_out,
  output logic                       imask_out,
  output logic                       fmask_out,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic                       irq
);
  import shiu_pkg::*;

  // ****************************************************************
  // Architectural state
  // ****************************************************************
  logic [31:0]       psw_reg;
  logic [31:0]       msp_reg;
  logic [31:0]       psp_reg;
  logic [7:0]        bpri_reg;
  logic              imask_reg;
  logic              fmask_reg;
  logic [1:0]        ctrl_word_reg;
  logic              event_reg;
  shiu_state_e       state_reg;
  shiu_state_e       state_next;
  logic [1:0]        cfg_reg;
  logic [3:0]        irq_st_reg;
  logic [3:0]        irq_mk_reg;
  logic [3:0]        irq_set;
  logic              issue;
  logic              msr_go;
  logic              wake_evt;
  logic              wake_int;
  logic              wfe_sleep;
  logic              apb_wr;
  logic              apb_rd;

  // Raise-only compare for the conditional base priority write
  function automatic logic bpri_raise(input logic [7:0] cur, input logic [7:0] val);
    bpri_raise = (val != 8'h00) && ((cur == 8'h00) || (cur > val));
  endfunction

  // Masked merge of a new value into an old word
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [31:0] sel);
    merge = (old_v & ~sel) | (new_v & sel);
  endfunction

  // ****************************************************************
  // Issue and wake decode
  // ****************************************************************
  assign instr_ready   = (state_reg == SHIU_RUN);
  assign issue         = instr.valid && instr_ready;
  assign msr_go        = issue && (instr.op == SHIU_OP_MSR);
  assign core_sleeping = (state_reg != SHIU_RUN);
  // Event sleep wake sources
  assign wake_evt = wake.exc_unmasked
                  || (wake.exc_new_pend && cfg_reg[SHIU_CTRL_EVPEND_POS])
                  || (wake.dbg_req && cfg_reg[SHIU_CTRL_DBGEN_POS])
                  || wake.ext_event;
  // Interrupt sleep ignores debug enable
  assign wake_int = wake.exc_any || wake.dbg_req;
  assign wfe_sleep = issue && (instr.op == SHIU_OP_WFE) && !event_reg;

  // Sleep state machine
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SHIU_RUN: begin
        if (wfe_sleep) begin
          state_next = SHIU_SLEEP_EVT;
        end else if (issue && (instr.op == SHIU_OP_WFI)) begin
          state_next = SHIU_SLEEP_INT;
        end
      end
      SHIU_SLEEP_EVT: begin
        if (wake_evt) begin
          state_next = SHIU_RUN;
        end
      end
      SHIU_SLEEP_INT: begin
        if (wake_int) begin
          state_next = SHIU_RUN;
        end
      end
      default: state_next = SHIU_RUN;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= SHIU_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Local event register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      event_reg <= SHIU_EVREG_RST;
    end else if (issue && (instr.op == SHIU_OP_SEV)) begin
      event_reg <= 1'b1;
    end else if (wake.ext_event && state_reg != SHIU_SLEEP_EVT) begin
      event_reg <= 1'b1;
    end else if (issue && (instr.op == SHIU_OP_WFE)) begin
      event_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Special register writes
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      psw_reg <= SHIU_WORD_RST;
    end else if (msr_go) begin
      if (instr.sreg == SHIU_SR_APP || !privileged) begin
        // Only flags change; other bits kept for unprivileged code
        psw_reg <= merge(psw_reg, instr.src, SHIU_APP_MASK);
      end else if (instr.sreg == SHIU_SR_PSW) begin
        psw_reg <= instr.src;
      end
    end
  end

  // Privileged-only special registers; flags untouched by these
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      msp_reg       <= SHIU_WORD_RST;
      psp_reg       <= SHIU_WORD_RST;
      bpri_reg      <= SHIU_BPRI_RST;
      imask_reg     <= 1'b0;
      fmask_reg     <= 1'b0;
      ctrl_word_reg <= 2'h0;
    end else if (msr_go && privileged) begin
      unique case (instr.sreg)
        SHIU_SR_MSP:   msp_reg <= instr.src;
        SHIU_SR_PSP:   psp_reg <= instr.src;
        SHIU_SR_IMASK: imask_reg <= instr.src[0];
        SHIU_SR_FMASK: fmask_reg <= instr.src[0];
        SHIU_SR_CTRL:  ctrl_word_reg <= instr.src[1:0];
        SHIU_SR_BPRI:  bpri_reg <= instr.src[7:0];
        SHIU_SR_BPMAX: begin
          if (bpri_raise(bpri_reg, instr.src[7:0])) begin
            bpri_reg <= instr.src[7:0];
          end
        end
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Pipeline results
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      result <= '0;
    end else begin
      result.rd_valid  <= issue && (instr.op == SHIU_OP_MRS);
      result.svc_raise <= issue && (instr.op == SHIU_OP_SVC);
      if (issue && (instr.op == SHIU_OP_SVC)) begin
        result.svc_imm <= instr.imm;
      end
      result.flush     <= issue && (instr.op == SHIU_OP_ISB);
      if (issue && (instr.op == SHIU_OP_MRS)) begin
        unique case (instr.sreg)
          SHIU_SR_APP:   result.rd_data <= psw_reg & SHIU_APP_MASK;
          SHIU_SR_PSW:   result.rd_data <= psw_reg;
          SHIU_SR_MSP:   result.rd_data <= msp_reg;
          SHIU_SR_PSP:   result.rd_data <= psp_reg;
          SHIU_SR_IMASK: result.rd_data <= {31'h0, imask_reg};
          SHIU_SR_FMASK: result.rd_data <= {31'h0, fmask_reg};
          SHIU_SR_CTRL:  result.rd_data <= {30'h0, ctrl_word_reg};
          SHIU_SR_BPRI,
          SHIU_SR_BPMAX: result.rd_data <= {24'h0, bpri_reg};
          default:       result.rd_data <= 32'h0;
        endcase
      end
    end
  end
  // No operation only retires; nothing else changes

  // Outgoing event pulse
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      event_out <= 1'b0;
    end else begin
      event_out <= issue && (instr.op == SHIU_OP_SEV);
    end
  end

  assign psw_out      = psw_reg;
  assign base_pri_out = bpri_reg;
  assign imask_out    = imask_reg;
  assign fmask_out    = fmask_reg;

  // ****************************************************************
  // APB slave and interrupt
  // ****************************************************************
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign apb_wr  = psel && penable && pwrite;
  assign apb_rd  = psel && !penable && !pwrite;

  // Event sources for the sticky status
  assign irq_set = {result.flush, state_reg != SHIU_RUN && state_next == SHIU_RUN,
                    event_out, result.svc_raise};

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfg_reg    <= SHIU_CTRL_RST;
      irq_mk_reg <= SHIU_IRQ_RST;
    end else if (apb_wr) begin
      if (paddr == SHIU_CTRL_OFF) begin
        cfg_reg <= pwdata[1:0];
      end
      if (paddr == SHIU_IRQ_MK_OFF) begin
        irq_mk_reg <= pwdata[SHIU_IRQ_W-1:0];
      end
    end
  end

  // Write one to clear; a new event wins over the clear
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irq_st_reg <= SHIU_IRQ_RST;
    end else begin
      if (apb_wr && paddr == SHIU_IRQ_ST_OFF) begin
        irq_st_reg <= (irq_st_reg & ~pwdata[SHIU_IRQ_W-1:0]) | irq_set;
      end else begin
        irq_st_reg <= irq_st_reg | irq_set;
      end
    end
  end

  // Read data registered in the setup cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0;
    end else if (apb_rd) begin
      unique case (paddr)
        SHIU_CTRL_OFF:   prdata <= {30'h0, cfg_reg};
        SHIU_STATE_OFF:  prdata <= {29'h0, event_reg, state_reg};
        SHIU_IRQ_ST_OFF: prdata <= {28'h0, irq_st_reg};
        SHIU_IRQ_MK_OFF: prdata <= {28'h0, irq_mk_reg};
        default:         prdata <= 32'h0;
      endcase
    end
  end

  assign irq = |(irq_st_reg & irq_mk_reg);

endmodule
`default_nettype wire

// *** tb/shiu_core_assertions.sv ***
// Checker on the top ports of the system hint instruction unit.
// Assumes one clock domain; bound to shiu_core after the module.
`timescale 1ns/1ps
`default_nettype none
module shiu_core_checker (
  input wire logic                  clock,
  input wire logic                  rst_b,
  input wire shiu_pkg::shiu_instr_s  instr,
  input wire logic                  privileged,
  input wire shiu_pkg::shiu_wake_s   wake,
  input wire shiu_pkg::shiu_result_s result,
  input wire logic                  instr_ready,
  input wire logic                  core_sleeping,
  input wire logic                  event_out,
  input wire logic [31:0]           psw_out,
  input wire logic [7:0]            base_pri_out,
  input wire logic                  imask_out,
  input wire logic                  fmask_out,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  irq
);
  import shiu_pkg::*;
  logic take;
  logic special_reg_write;
  // Accepted instruction and its write flavour
  assign take = instr.valid && instr_ready;
  assign special_reg_write  = take && instr.op == SHIU_OP_MSR;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // ****************************************************************
  // Instruction outcomes
  // ****************************************************************
  property p_isb; take && instr.op == SHIU_OP_ISB |=> result.flush; endproperty
  a_isb: assert property (p_isb) else $error("barrier gave no flush");
  property p_rd; take && instr.op == SHIU_OP_MRS && instr.sreg == SHIU_SR_BPMAX
    |=> result.rd_valid && result.rd_data == {24'h00, $past(base_pri_out)}; endproperty
  a_rd: assert property (p_rd) else $error("alias read wrong");
  property p_unpr; special_reg_write && !privileged |=> $stable(base_pri_out) && $stable(imask_out)
    && $stable(fmask_out) && psw_out[26:0] == $past(psw_out[26:0]); endproperty
  a_unpr: assert property (p_unpr) else $error("unprivileged write leaked");
  property p_hold; special_reg_write && privileged && instr.sreg == SHIU_SR_BPMAX && (instr.src[7:0] == 8'h00
    || (base_pri_out != 8'h00 && instr.src[7:0] >= base_pri_out)) |=> $stable(base_pri_out);
  endproperty
  a_hold: assert property (p_hold) else $error("alias lowered priority");
  property p_flag; special_reg_write && (!privileged || instr.sreg == SHIU_SR_APP || instr.sreg == SHIU_SR_PSW)
    |=> psw_out[31:27] == $past(instr.src[31:27]); endproperty
  a_flag: assert property (p_flag) else $error("flags not from source");
  property p_sev; take && instr.op == SHIU_OP_SEV |=> event_out; endproperty
  a_sev: assert property (p_sev) else $error("no event pulse");
  property p_svc; take && instr.op == SHIU_OP_SVC
    |=> result.svc_raise && result.svc_imm == $past(instr.imm); endproperty
  a_svc: assert property (p_svc) else $error("supervisor call lost");
  property p_wfi; take && instr.op == SHIU_OP_WFI |=> core_sleeping && !instr_ready; endproperty
  a_wfi: assert property (p_wfi) else $error("interrupt wait did not sleep");
  property p_keep; take && instr.op != SHIU_OP_MSR |=> $stable(psw_out[31:27]); endproperty
  a_keep: assert property (p_keep) else $error("flags moved");
  property p_wake; core_sleeping && wake.exc_any && wake.exc_unmasked |=> !core_sleeping;
  endproperty
  a_wake: assert property (p_wake) else $error("exception did not wake");
  c_wfe: cover property (take && instr.op == SHIU_OP_WFE);
  c_nap: cover property (core_sleeping ##1 !core_sleeping);
  c_irq: cover property (irq);
endmodule
bind shiu_core shiu_core_checker i_shiu_core_checker (
  .clock, .rst_b, .instr, .privileged, .wake, .result, .instr_ready,
  .core_sleeping, .event_out, .psw_out, .base_pri_out, .imask_out, .fmask_out,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq
);
`default_nettype wire

// *** tb/shiu_wake_model.sv ***
// Model of the exception and debug side: one wake pulse per request.
// Assumes the bench holds want until the core is awake again.
`timescale 1ns/1ps
`default_nettype none
module shiu_wake_model (
  input  wire logic                 clock,
  input  wire logic                 rst_b,
  input  wire shiu_pkg::shiu_wake_s want,
  input  wire logic [3:0]           delay,
  output var  shiu_pkg::shiu_wake_s wake
);
  import shiu_pkg::*;
  logic [4:0] cnt_reg;
  // Single pulse delay cycles after the request, prompt or slow
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 5'h00;
      wake    <= '0;
    end else begin
      wake <= '0;
      if (want == '0) begin
        cnt_reg <= 5'h00;
      end else if (cnt_reg <= {1'b0, delay}) begin
        cnt_reg <= cnt_reg + 5'h01;
        if (cnt_reg == {1'b0, delay}) wake <= want;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/tb_system_hint_instruction_unit.sv ***
// Testbench for the system hint instruction unit.
// Assumes the checker is bound and the wake model stands in for exceptions.
`timescale 1ns/1ps
`default_nettype none
module tb_system_hint_instruction_unit;
  import shiu_pkg::*;
  logic clock, rst_b, privileged, instr_ready, core_sleeping, event_out;
  logic imask_out, fmask_out, psel, penable, pwrite, pready, pslverr, irq;
  logic [31:0] psw_out, pwdata, prdata, rd;
  logic [7:0] base_pri_out, paddr;
  logic [3:0] delay;
  shiu_instr_s instr;
  shiu_wake_s wake, want;
  shiu_result_s result;
  int failures, checks_done, cycles;
  always #2 clock = ~clock;
  shiu_core i_shiu_core (.clock, .rst_b, .instr, .privileged, .wake, .result, .instr_ready,
    .core_sleeping, .event_out, .psw_out, .base_pri_out, .imask_out, .fmask_out,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq);
  shiu_wake_model i_shiu_wake_model (.clock, .rst_b, .want, .delay, .wake);
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic issue(input shiu_op_e op, input shiu_sreg_e sr, input logic [31:0] src,
                       input logic [7:0] imm);
    @(posedge clock);
    instr <= '{1'b1, op, sr, src, imm};
    @(posedge clock);
    instr.valid <= 1'b0;
    #1;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rv);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    // Ends at the first edge that sees pready high; the core ties it to 1
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Sleep hint, then wake through the model and wait bounded
  task automatic nap(input shiu_op_e op, input logic [4:0] w, input logic [3:0] d);
    int n;
    apb(1'b0, SHIU_STATE_OFF, 32'h0, rd);
    if (rd[2] === 1'b1) issue(SHIU_OP_WFE, SHIU_SR_APP, 32'h0, 8'h00);
    issue(op, SHIU_SR_APP, 32'h0, 8'h00);
    chk("asleep", 32'h1, {31'h0, core_sleeping});
    @(posedge clock);
    want <= shiu_wake_s'(w);
    delay <= d;
    n = 0;
    while (core_sleeping !== 1'b0 && n < 40) begin
      @(posedge clock);
      n++;
    end
    #1;
    chk("awake", 32'h1, {31'h0, instr_ready});
    @(posedge clock);
    want <= '0;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_sreg();
    logic [7:0] src_tab[4];
    logic [7:0] exp_tab[4];
    src_tab = '{8'h00, 8'h60, 8'h40, 8'h20};
    exp_tab = '{8'h40, 8'h40, 8'h40, 8'h20};
    chk("reset_psw", 32'h0, psw_out);
    issue(SHIU_OP_MSR, SHIU_SR_PSW, 32'hA800_0200, 8'h00);
    chk("psw", 32'hA800_0200, psw_out);
    @(posedge clock);
    privileged <= 1'b0;
    issue(SHIU_OP_MSR, SHIU_SR_PSW, 32'h57FF_FFFF, 8'h00);
    chk("psw_unpriv", 32'h5000_0200, psw_out);
    issue(SHIU_OP_MSR, SHIU_SR_BPRI, 32'h40, 8'h00);
    chk("bpri_unpriv", 32'h0, {24'h0, base_pri_out});
    @(posedge clock);
    privileged <= 1'b1;
    issue(SHIU_OP_MSR, SHIU_SR_BPRI, 32'h40, 8'h00);
    issue(SHIU_OP_MRS, SHIU_SR_BPMAX, 32'h0, 8'h00);
    chk("rd_alias", 32'h40, result.rd_data);
    for (int i = 0; i < 4; i++) begin
      issue(SHIU_OP_MSR, SHIU_SR_BPMAX, {24'h0, src_tab[i]}, 8'h00);
      chk("bpri_alias", {24'h0, exp_tab[i]}, {24'h0, base_pri_out});
    end
    issue(SHIU_OP_MSR, SHIU_SR_BPRI, 32'h0, 8'h00);
    issue(SHIU_OP_MSR, SHIU_SR_BPMAX, 32'h30, 8'h00);
    chk("bpri_zero", 32'h30, {24'h0, base_pri_out});
    issue(SHIU_OP_MSR, SHIU_SR_IMASK, 32'h1, 8'h00);
    issue(SHIU_OP_MRS, SHIU_SR_IMASK, 32'h0, 8'h00);
    chk("rd_imask", 32'h1, result.rd_data);
    chk("imask", 32'h1, {31'h0, imask_out});
    issue(SHIU_OP_MSR, SHIU_SR_FMASK, 32'h1, 8'h00);
    chk("fmask", 32'h1, {31'h0, fmask_out});
    issue(SHIU_OP_MSR, SHIU_SR_PSP, 32'h1234_5678, 8'h00);
    issue(SHIU_OP_MRS, SHIU_SR_PSP, 32'h0, 8'h00);
    chk("rd_psp", 32'h1234_5678, result.rd_data);
    chk("rd_valid", 32'h1, {31'h0, result.rd_valid});
    $display("test sreg done");
  endtask
  task automatic t_misc();
    issue(SHIU_OP_NOP, SHIU_SR_APP, 32'hFFFF_FFFF, 8'h00);
    chk("nop_psw", 32'h0000_0200, psw_out);
    issue(SHIU_OP_ISB, SHIU_SR_APP, 32'hFFFF_FFFF, 8'h00);
    chk("flush", 32'h1, {31'h0, result.flush});
    chk("isb_psw", 32'h0000_0200, psw_out);
    issue(SHIU_OP_SVC, SHIU_SR_APP, 32'h0, 8'hFF);
    chk("svc", 32'h1FF, {23'h0, result.svc_raise, result.svc_imm});
    $display("test misc done");
  endtask
  task automatic t_sleep();
    apb(1'b0, SHIU_STATE_OFF, 32'h0, rd);
    chk("event_reset", 32'h0, {31'h0, rd[2]});
    nap(SHIU_OP_WFE, 5'b00001, 4'h3);
    issue(SHIU_OP_SEV, SHIU_SR_APP, 32'h0, 8'h00);
    chk("event_out", 32'h1, {31'h0, event_out});
    apb(1'b0, SHIU_STATE_OFF, 32'h0, rd);
    chk("event_set", 32'h1, {31'h0, rd[2]});
    issue(SHIU_OP_WFE, SHIU_SR_APP, 32'h0, 8'h00);
    chk("wfe_runs", 32'h0, {31'h0, core_sleeping});
    apb(1'b0, SHIU_STATE_OFF, 32'h0, rd);
    chk("event_clr", 32'h0, {31'h0, rd[2]});
    nap(SHIU_OP_WFE, 5'b11000, 4'h0);
    apb(1'b1, SHIU_CTRL_OFF, 32'h3, rd);
    nap(SHIU_OP_WFE, 5'b00100, 4'h2);
    nap(SHIU_OP_WFI, 5'b01000, 4'h6);
    apb(1'b1, SHIU_CTRL_OFF, 32'h0, rd);
    // Gated sources must not end an event sleep
    issue(SHIU_OP_WFE, SHIU_SR_APP, 32'h0, 8'h00);
    @(posedge clock);
    delay <= 4'h0;
    want <= shiu_wake_s'(5'b00110);
    repeat (4) @(posedge clock);
    #1;
    chk("wfe_gated", 32'h1, {31'h0, core_sleeping});
    @(posedge clock);
    want <= '0;
    @(posedge clock);
    want <= shiu_wake_s'(5'b00001);
    repeat (3) @(posedge clock);
    #1;
    chk("wfe_woken", 32'h1, {31'h0, instr_ready});
    @(posedge clock);
    want <= '0;
    nap(SHIU_OP_WFI, 5'b00010, 4'h1);
    $display("test sleep done");
  endtask
  task automatic t_irq();
    apb(1'b1, SHIU_IRQ_ST_OFF, 32'hF, rd);
    apb(1'b1, SHIU_IRQ_MK_OFF, 32'h1, rd);
    chk("irq_idle", 32'h0, {31'h0, irq});
    issue(SHIU_OP_SVC, SHIU_SR_APP, 32'h0, 8'h00);
    repeat (2) @(posedge clock);
    chk("irq_set", 32'h1, {31'h0, irq});
    apb(1'b0, SHIU_IRQ_ST_OFF, 32'h0, rd);
    chk("status", 32'h1, rd);
    apb(1'b1, SHIU_IRQ_ST_OFF, 32'h1, rd);
    repeat (2) @(posedge clock);
    chk("irq_clr", 32'h0, {31'h0, irq});
    apb(1'b0, SHIU_IRQ_MK_OFF, 32'h0, rd);
    chk("mask", 32'h1, rd);
    apb(1'b0, 8'h10, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    chk("pslverr", 32'h0, {31'h0, pslverr});
    $display("test irq done");
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    {clock, rst_b, psel, penable, pwrite} = '0;
    privileged = 1'b1;
    instr = '0;
    want = '0;
    delay = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    {failures, checks_done, cycles} = '0;
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    t_sreg();
    t_misc();
    t_sleep();
    t_irq();
    finish_test();
  end
endmodule
`default_nettype wire
